/* rtl/rx_status_bist.sv */
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module rx_status_bist
  import rx_status_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input rx_char_s rx_char,
  input pattern_s pattern,
  input wire logic lock_lost,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output rx_out_s rx_out,
  output logic pattern_run,
  output logic pattern_step
);

  // control and apb state
  logic [1:0] ctrl_reg, ctrl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  // self-test state
  bist_state_e state_reg, state_next;
  logic [3:0] recenter_reg, recenter_next;
  rx_out_s out_reg, out_next;
  logic run_reg, run_next;
  logic step_reg, step_next;
  logic bal_clear, bal_err, bal_match, bal_over;
  logic [BAL_W-1:0] bal_count;
  logic [2:0] normal_status;
  logic selftest_en, type_b, live, is_match, is_start;

  assign selftest_en = ctrl_reg[CTRL_EN_BIT];
  assign type_b = ctrl_reg[CTRL_TYPE_BIT];

  status_encoder u_enc (
    .ch(rx_char),
    .lock_lost(lock_lost),
    .type_b(type_b),
    .status(normal_status)
  );

  balance_counter u_bal (
    .clk(clk),
    .rstn(rstn),
    .clear(bal_clear),
    .err(bal_err),
    .match(bal_match),
    .count(bal_count),
    .over(bal_over)
  );

  // a character the compare machine may act on: no lock or buffer trouble
  assign live = rx_char.valid && selftest_en && !lock_lost && !rx_char.ebuf_err && recenter_reg == '0;
  assign is_match = rx_char.data == pattern.data && rx_char.is_cmd == pattern.is_cmd
                    && !rx_char.code_viol && !rx_char.disp_err;
  assign is_start = rx_char.data == START_CHAR && !rx_char.is_cmd && !rx_char.code_viol;
  assign bal_err = live && state_reg == compare_state && !is_match;
  assign bal_match = live && state_reg == compare_state && is_match;
  assign bal_clear = state_reg != compare_state;

  // apb slave: no wait state, answer prepared during the setup cycle
  always_comb
  begin
    ctrl_next = ctrl_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = psel && !penable && !pready_reg;
    if (psel && !penable && !pready_reg)
    begin
      prdata_next = '0;
      if (paddr == ADDR_CTRL)
        prdata_next = {30'h0, ctrl_reg};
      else if (paddr == ADDR_STATUS)
        prdata_next = {25'h0, lock_lost, recenter_reg != '0, out_reg.status, state_reg};
      else if (paddr == ADDR_BALANCE)
        prdata_next = {{(32-BAL_W){bal_count[BAL_W-1]}}, bal_count};
      else
        pslverr_next = 1'b1;
    end
    if (psel && penable && pready_reg && pwrite && paddr == ADDR_CTRL)
      ctrl_next = pwdata[1:0];
    if (psel && penable && pready_reg)
      pslverr_next = pslverr_reg;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= CTRL_RESET;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // self-test compare machine and status output register
  always_comb
  begin
    state_next = state_reg;
    recenter_next = recenter_reg;
    run_next = run_reg;
    step_next = 1'b0;
    out_next = out_reg;
    out_next.valid = rx_char.valid;
    if (rx_char.valid)
    begin
      out_next.data = rx_char.data;
      out_next.status = normal_status;
    end
    if (lock_lost || !selftest_en)
    begin
      state_next = selftest_start_state;
      run_next = 1'b0;
      recenter_next = '0;
      if (rx_char.valid && selftest_en)
        out_next.status = ST_LOCK;
    end
    else if (rx_char.valid && (rx_char.ebuf_err || recenter_reg != '0))
    begin
      // buffer is re-centring; counting characters, not cycles
      state_next = selftest_start_state;
      run_next = 1'b0;
      recenter_next = rx_char.ebuf_err ? RECENTER_CHARS : recenter_reg - 4'h1;
      out_next.status = ST_LOCK;
    end
    else if (live)
    begin
      case (state_reg)
        selftest_start_state:
        begin
          state_next = pattern_wait_state;
          out_next.status = ST_LOCK;
        end
        pattern_wait_state:
        begin
          if (is_start)
          begin
            state_next = compare_state;
            run_next = 1'b1;
            step_next = 1'b1;
            out_next.status = ST_NORMAL;
          end
          else
            out_next.status = ST_WAIT;
        end
        default:
        begin
          step_next = 1'b1;
          if (pattern.last)
          begin
            // sequence done; next one restarts at the start character
            state_next = pattern_wait_state;
            run_next = 1'b0;
            out_next.status = is_match ? ST_LAST_GOOD : ST_LAST_BAD;
          end
          else if (!is_match)
            out_next.status = ST_DISP;
          else if (rx_char.is_cmd)
            out_next.status = ST_CMD_OK;
          else
            out_next.status = ST_NORMAL;
          if (bal_over && !pattern.last)
          begin
            state_next = pattern_wait_state;
            run_next = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= selftest_start_state;
      recenter_reg <= '0;
      out_reg <= '0;
      run_reg <= 1'b0;
      step_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      recenter_reg <= recenter_next;
      out_reg <= out_next;
      run_reg <= run_next;
      step_reg <= step_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rx_out = out_reg;
  assign pattern_run = run_reg;
  assign pattern_step = step_reg;

  // framing code and data travel together; the status output register keeps the decoded value
  a_lock_to_start: assert property (@(posedge clk) disable iff (!rstn)
    lock_lost |=> state_reg == selftest_start_state)
    else $error("lock loss did not force start state");

  a_balance_to_wait: assert property (@(posedge clk) disable iff (!rstn)
    live && state_reg == compare_state && bal_over && !pattern.last |=> state_reg == pattern_wait_state)
    else $error("error surplus did not drop to wait state");

  a_ebuf_holds_start: assert property (@(posedge clk) disable iff (!rstn)
    selftest_en && !lock_lost && rx_char.valid && rx_char.ebuf_err
    |=> recenter_reg == RECENTER_CHARS && out_reg.status == ST_LOCK)
    else $error("buffer fault not held at start code");

  a_compare_data_ok: assert property (@(posedge clk) disable iff (!rstn)
    live && state_reg == compare_state && is_match && !rx_char.is_cmd && !pattern.last
    |=> out_reg.status == ST_NORMAL && $past(step_next))
    else $error("good data compare not reported");

  a_compare_cmd_ok: assert property (@(posedge clk) disable iff (!rstn)
    live && state_reg == compare_state && is_match && rx_char.is_cmd && !pattern.last
    |=> out_reg.status == ST_CMD_OK)
    else $error("good command compare not reported");

  a_last_good_bad: assert property (@(posedge clk) disable iff (!rstn)
    live && state_reg == compare_state && pattern.last
    |=> out_reg.status == ($past(is_match) ? ST_LAST_GOOD : ST_LAST_BAD) && state_reg == pattern_wait_state)
    else $error("last pattern character misreported");

  a_framing_code: assert property (@(posedge clk) disable iff (!rstn)
    !selftest_en && rx_char.valid && !lock_lost && !rx_char.ebuf_err && !rx_char.code_viol && rx_char.framing
    |=> out_reg.status == ST_FRAMING && out_reg.data == $past(rx_char.data))
    else $error("framing character misreported");

  a_viol_over_disp: assert property (@(posedge clk) disable iff (!rstn)
    !selftest_en && rx_char.valid && !lock_lost && !rx_char.ebuf_err && rx_char.code_viol
    |=> out_reg.status == ST_CODE_VIOL)
    else $error("codeword violation misreported");

  a_lock_wins: assert property (@(posedge clk) disable iff (!rstn)
    rx_char.valid && lock_lost |=> out_reg.status == ST_LOCK && out_reg.valid)
    else $error("lock loss did not win status");

  a_mismatch_code: assert property (@(posedge clk) disable iff (!rstn)
    live && state_reg == compare_state && !is_match && !pattern.last |=> out_reg.status == ST_DISP)
    else $error("compare mismatch not reported");

  a_wait_code: assert property (@(posedge clk) disable iff (!rstn)
    live && state_reg == pattern_wait_state && !is_start
    |=> out_reg.status == ST_WAIT && state_reg == pattern_wait_state)
    else $error("wait state code wrong");

  a_type_select: assert property (@(posedge clk) disable iff (!rstn)
    !selftest_en && rx_char.valid && !lock_lost && rx_char.ebuf_err
    |=> out_reg.status == ($past(type_b) ? $past(normal_status) : ST_EBUF)
    && out_reg.status != ($past(type_b) ? ST_EBUF : ST_NORMAL))
    else $error("status type selection wrong");

  // lock outranks every decoder fault on the same character
  a_lock_over_faults: assert property (@(posedge clk) disable iff (!rstn)
    rx_char.valid && lock_lost && rx_char.ebuf_err && rx_char.code_viol
    |=> out_reg.status == ST_LOCK)
    else $error("lock loss lost to a lower priority fault");

  // framing outranks a disparity error on the same character
  a_framing_over_disp: assert property (@(posedge clk) disable iff (!rstn)
    !selftest_en && rx_char.valid && !lock_lost && !(rx_char.ebuf_err && !type_b) && !rx_char.code_viol
    && rx_char.framing && rx_char.disp_err
    |=> out_reg.status == ST_FRAMING)
    else $error("framing did not outrank disparity error");

  // each later character without a buffer fault counts the re-centring down by one, until it reaches zero
  // and keeps the machine parked, so no compare starts on a half-centred buffer
  a_recenter_count: assert property (@(posedge clk) disable iff (!rstn)
    selftest_en && !lock_lost && rx_char.valid && !rx_char.ebuf_err && recenter_reg != '0
    |=> out_reg.status == ST_LOCK && recenter_reg == $past(recenter_reg) - 4'h1
    && state_reg == selftest_start_state)
    else $error("re-centring count or start code wrong");

endmodule

/* rtl/rx_status_pkg.sv */
package rx_status_pkg;

  // character status codes, normal and self-test meanings share encodings
  localparam logic [2:0] ST_NORMAL = 3'h0;      // normal char / data compared ok
  localparam logic [2:0] ST_CMD_OK = 3'h1;      // command compared ok
  localparam logic [2:0] ST_EBUF = 3'h2;        // buffer fault (type a) / last good
  localparam logic [2:0] ST_FRAMING = 3'h3;     // framing character seen
  localparam logic [2:0] ST_CODE_VIOL = 3'h4;   // codeword violation / last bad
  localparam logic [2:0] ST_LOCK = 3'h5;        // loss of lock / self-test start
  localparam logic [2:0] ST_DISP = 3'h6;        // disparity error / compare error
  localparam logic [2:0] ST_WAIT = 3'h7;        // reserved / waiting for start char
  localparam logic [2:0] ST_LAST_GOOD = ST_EBUF;
  localparam logic [2:0] ST_LAST_BAD = ST_CODE_VIOL;

  // first pattern character of a sequence, a data character of value zero
  localparam logic [7:0] START_CHAR = 8'h00;
  // error surplus over matches beyond which the compare gives up
  localparam int BAL_LIMIT = 16;
  localparam int BAL_W = 7;
  // characters the elastic buffer needs to re-centre
  localparam logic [3:0] RECENTER_CHARS = 4'h9;

  // register map, byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_BALANCE = 12'h008;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TYPE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  typedef enum logic [1:0] {selftest_start_state, pattern_wait_state, compare_state} bist_state_e;

  // one received character with its decoder flags
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic is_cmd;
    logic code_viol;
    logic disp_err;
    logic framing;
    logic ebuf_err;
  } rx_char_s;

  // expected pattern character from the pattern generator
  typedef struct packed {
    logic [7:0] data;
    logic is_cmd;
    logic last;
  } pattern_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [2:0] status;
  } rx_out_s;

endpackage

/* rtl/status_encoder.sv */
`timescale 1ns/1ps
module status_encoder
  import rx_status_pkg::*;
(
  input rx_char_s ch,
  input wire logic lock_lost,
  input wire logic type_b,
  output logic [2:0] status
);

  // lowest priority number wins; type b leaves buffer faults unreported
  always_comb
  begin
    if (lock_lost)
      status = ST_LOCK;
    else if (ch.ebuf_err && !type_b)
      status = ST_EBUF;
    else if (ch.code_viol)
      status = ST_CODE_VIOL;
    else if (ch.framing)
      status = ST_FRAMING;
    else if (ch.disp_err)
      status = ST_DISP;
    else
      status = ST_NORMAL;
  end

endmodule

/* rtl/balance_counter.sv */
`timescale 1ns/1ps
module balance_counter
  import rx_status_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic err,
  input wire logic match,
  output logic [BAL_W-1:0] count,
  output logic over
);

  // a one-bit signed literal reads as minus one, so the step is spelt out at full width
  localparam logic signed [BAL_W-1:0] BAL_ONE = BAL_W'(1);

  logic signed [BAL_W-1:0] bal_reg;
  logic signed [BAL_W-1:0] bal_next;

  // errors minus matches, saturating so a long good run cannot wrap
  always_comb
  begin
    bal_next = bal_reg;
    if (clear)
      bal_next = '0;
    else if (err && bal_reg != {1'b0, {(BAL_W-1){1'b1}}})
      bal_next = bal_reg + BAL_ONE;
    else if (match && bal_reg != {1'b1, {(BAL_W-1){1'b0}}})
      bal_next = bal_reg - BAL_ONE;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      bal_reg <= '0;
    else
      bal_reg <= bal_next;
  end

  assign count = bal_reg;
  assign over = bal_reg > BAL_W'(BAL_LIMIT);

endmodule

/* dv/pattern_source.sv */
`timescale 1ns/1ps
// far-side pattern generator feeding the expected characters
module pattern_source
  import rx_status_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic step,
  input wire logic [7:0] seq_len,
  output pattern_s pattern
);
  logic [7:0] idx_reg;
  logic [7:0] idx_next;

  // step wins over a dropped run, since run drops with the last step of a sequence
  always_comb
  begin
    idx_next = idx_reg;
    if (step)
      idx_next = idx_reg + 8'h01;
    else if (!run)
      idx_next = 8'h00;
  end

  // shares the bench clock with the receiver
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      idx_reg <= 8'h00;
    else
      idx_reg <= idx_next;
  end

  // fixed short sequence; later entries just count, to run long
  always_comb
  begin
    pattern.data = (idx_reg == 8'h01) ? 8'h11 : (idx_reg == 8'h02) ? 8'hbc : (idx_reg == 8'h03) ? 8'h22 : idx_reg;
    pattern.is_cmd = (idx_reg == 8'h02);
    pattern.last = (idx_reg == seq_len);
  end
endmodule

/* dv/receive_status_and_bist_monitor_test.sv */
`timescale 1ns/1ps
module receive_status_and_bist_monitor_test
  import rx_status_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  rx_char_s rx_char = '0;
  pattern_s pattern;
  logic lock_lost = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rx_out_s rx_out;
  logic pattern_run;
  logic pattern_step;
  logic [7:0] seq_len = 8'h03;
  int error_cnt = 0;
  int tests_run = 0;
  logic [2:0] st;
  logic [7:0] dat;
  logic [31:0] rd;
  logic err;
  // normal rows: type_b, lock, {cmd, viol, disp, framing, ebuf}, status
  logic [9:0] rows [12] = '{10'b0_0_00000_000, 10'b0_1_00000_101, 10'b0_0_00001_010, 10'b1_0_00001_000,
    10'b0_0_01000_100, 10'b0_0_00010_011, 10'b0_0_00100_110, 10'b0_0_01100_100, 10'b0_0_01001_010,
    10'b1_1_01001_101, 10'b1_0_00110_011, 10'b1_0_01001_100};
  // self-test rows: data, flags, status
  logic [15:0] sq [10] = '{16'h5505, 16'h5507, 16'h0000, 16'h1100, 16'hbc81, 16'h2202, 16'h0000, 16'h9906,
    16'hbc81, 16'h2304};

  always #5 clk = ~clk;

  rx_status_bist dut (.clk(clk), .rstn(rstn), .rx_char(rx_char), .pattern(pattern), .lock_lost(lock_lost),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_out(rx_out), .pattern_run(pattern_run), .pattern_step(pattern_step));

  pattern_source host (.clk(clk), .rstn(rstn), .run(pattern_run), .step(pattern_step), .seq_len(seq_len),
    .pattern(pattern));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the request holds until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no cycle count assumed; a hang is ended by the watchdog
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one character, spaced so the generator has stepped before the next
  task send(input logic [7:0] d, input logic [4:0] f);
    @(posedge clk);
    rx_char <= {1'b1, d, f};
    @(posedge clk);
    rx_char.valid <= 1'b0;
    #1;
    st = rx_out.status;
    dat = rx_out.data;
    chk(rx_out.valid, 32'h1);
    @(posedge clk);
  endtask

  task results;
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // whole run is a few hundred cycles; this is ample margin
  initial
  begin
    #100000;
    error_cnt++;
    results;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    chk(rx_out, 32'h0);
    chk(pattern_run, 32'h0);
    rstn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'(CTRL_RESET));
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hff);
    chk(err, 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      apb(1'b1, ADDR_CTRL, {30'h0, rows[i][9], 1'b0});
      lock_lost <= rows[i][8];
      send(8'h5a, rows[i][7:3]);
      lock_lost <= 1'b0;
      chk(st, rows[i][2:0]);
      chk(dat, 8'h5a);
    end
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 10; i++)
    begin
      send(sq[i][15:8], sq[i][7:3]);
      chk(st, sq[i][2:0]);
    end
    chk(pattern_run, 32'h0);
    // lock loss in mid-compare
    send(8'h00, 5'h00);
    chk(pattern_run, 32'h1);
    @(posedge clk);
    lock_lost <= 1'b1;
    @(posedge clk);
    lock_lost <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[1:0], 32'h0);
    send(8'h55, 5'h00);
    chk(st, ST_LOCK);
    // buffer fault while comparing, then re-centring
    seq_len <= 8'h28;
    send(8'h00, 5'h00);
    send(8'h55, 5'h01);
    chk(st, ST_LOCK);
    repeat (9)
    begin
      send(8'h00, 5'h00);
      chk(st, ST_LOCK);
    end
    send(8'h55, 5'h00);
    send(8'h55, 5'h00);
    send(8'h00, 5'h00);
    chk(st, ST_NORMAL);
    // error surplus just past the limit
    repeat (BAL_LIMIT + 1)
    begin
      send(8'hff, 5'h00);
      chk(st, ST_DISP);
    end
    apb(1'b0, ADDR_BALANCE, 32'h0);
    chk(rd, 32'(BAL_LIMIT + 1));
    send(8'hff, 5'h00);
    chk(st, ST_DISP);
    send(8'h55, 5'h00);
    chk(st, ST_WAIT);
    results;
  end
endmodule
